// File: tsc_pkg.sv
package tsc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int IMG_W = 16;
  localparam int VAL_W = 13;
  localparam int CNT_W = 3;
  localparam int RATE_CNT_W = 28;

  // ----------------------------------------------------------------
  // Field positions in the high and low byte
  // ----------------------------------------------------------------
  localparam int HI_IDLE = 7;
  localparam int HI_RES_HI = 6;
  localparam int HI_RES_LO = 5;
  localparam int HI_FQ_HI = 4;
  localparam int HI_FQ_LO = 3;
  localparam int HI_POL = 2;
  localparam int HI_TM = 1;
  localparam int HI_SD = 0;
  localparam int LO_RATE_HI = 7;
  localparam int LO_RATE_LO = 6;
  localparam int LO_FLAG = 5;
  localparam int LO_EM = 4;
  localparam int LO_RSV_HI = 3;
  localparam int LO_RSV_LO = 0;

  // ----------------------------------------------------------------
  // Fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_CODE = 2'h3;
  localparam logic [3:0] RSV_VALUE = 4'h0;
  localparam logic IDLE_RESET = 1'h0;

  typedef struct packed {
    logic [1:0] fault_q;
    logic alert_active_level;
    logic tm;
    logic sd;
    logic [1:0] rate;
    logic em;
  } tsc_ctrl_t;

  localparam tsc_ctrl_t CTRL_RESET = '{fault_q: 2'h0, alert_active_level: 1'h0, tm: 1'h0, sd: 1'h0,
                                       rate: 2'h2, em: 1'h0};

  // ----------------------------------------------------------------
  // Fault queue codes and needed counts
  // ----------------------------------------------------------------
  localparam logic [1:0] FQ_ONE = 2'h0;
  localparam logic [1:0] FQ_TWO = 2'h1;
  localparam logic [1:0] FQ_FOUR = 2'h2;
  localparam logic [CNT_W-1:0] NEED_ONE = 3'h1;
  localparam logic [CNT_W-1:0] NEED_TWO = 3'h2;
  localparam logic [CNT_W-1:0] NEED_FOUR = 3'h4;
  localparam logic [CNT_W-1:0] NEED_SIX = 3'h6;

  // ----------------------------------------------------------------
  // Conversion periods
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_QUARTER = 2'h0;
  localparam logic [1:0] RATE_ONE = 2'h1;
  localparam logic [1:0] RATE_FOUR = 2'h2;
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int PERIOD_QUARTER_MS = 4000;
  localparam int PERIOD_ONE_MS = 1000;
  localparam int PERIOD_FOUR_MS = 250;
  localparam int PERIOD_EIGHT_MS = 125;
  localparam int CYC_QUARTER = CLK_HZ / MS_PER_S * PERIOD_QUARTER_MS;
  localparam int CYC_ONE = CLK_HZ / MS_PER_S * PERIOD_ONE_MS;
  localparam int CYC_FOUR = CLK_HZ / MS_PER_S * PERIOD_FOUR_MS;
  localparam int CYC_EIGHT = CLK_HZ / MS_PER_S * PERIOD_EIGHT_MS;

  typedef enum logic {
    TSC_BYTE_HI = 1'b0,
    TSC_BYTE_LO = 1'b1
  } tsc_byte_t;

  function automatic logic [CNT_W-1:0] tsc_fault_need(input logic [1:0] code);
    if (code == FQ_ONE) begin
      return NEED_ONE;
    end else if (code == FQ_TWO) begin
      return NEED_TWO;
    end else if (code == FQ_FOUR) begin
      return NEED_FOUR;
    end else begin
      return NEED_SIX;
    end
  endfunction

  // Left-justified image to signed value; extended images carry one more bit.
  function automatic logic signed [VAL_W-1:0] tsc_value(input logic [IMG_W-1:0] img,
                                                         input logic em);
    if (em) begin
      return img[IMG_W-1:IMG_W-VAL_W];
    end else begin
      return {img[IMG_W-1], img[IMG_W-1:IMG_W-VAL_W+1]};
    end
  endfunction

endpackage

// File: tsc_fault_filter.sv
module tsc_fault_filter (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_in,
  // Results and limits
  input wire logic sample_in,
  input wire logic signed [tsc_pkg::VAL_W-1:0] temp_in,
  input wire logic signed [tsc_pkg::VAL_W-1:0] upper_in,
  input wire logic signed [tsc_pkg::VAL_W-1:0] lower_in,
  input wire logic [1:0] fault_q_in,
  // Alarm state
  output logic active_out,
  output logic change_out
);
  import tsc_pkg::*;

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_active;
  logic next_change;
  logic hit;

  // Counts consecutive faults toward the opposite state, with hysteresis.
  always_comb begin
    next_count = count;
    next_active = active_out;
    next_change = 1'b0;
    hit = active_out ? (temp_in < lower_in) : (temp_in >= upper_in);
    if (clear_in) begin
      next_count = '0;
      next_active = 1'b0;
    end else if (sample_in) begin
      if (!hit) begin
        next_count = '0;
      end else if (count + NEED_ONE >= tsc_fault_need(fault_q_in)) begin
        next_count = '0;
        next_active = !active_out;
        next_change = 1'b1;
      end else begin
        next_count = count + NEED_ONE;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
      active_out <= 1'b0;
      change_out <= 1'b0;
    end else begin
      count <= next_count;
      active_out <= next_active;
      change_out <= next_change;
    end
  end

endmodule

// File: tsc_config_regs.sv
// How it works
// - Sixteen-bit register, high byte then low byte.
// - Status bit reads one when not converting.
// - Resolution code always reads binary eleven.
// - Fault code selects one, two, four, six.
// - Polarity bit sets alert active level.
// - Rate code selects conversion period.
// - Flag clears after consecutive upper-limit faults.
// - Flag returns after consecutive below-lower results.
// - Polarity one inverts the flag sense.
// - Flag ignores comparator or interrupt mode.
// - Range bit switches result and limit format.
// - Alert response acknowledged and alert released in the same cycle, interrupt mode only.
// - General-call reset restores defaults, aborts conversion.
module tsc_config_regs #(
  parameter int CYC_QUARTER_P = tsc_pkg::CYC_QUARTER,
  parameter int CYC_ONE_P = tsc_pkg::CYC_ONE,
  parameter int CYC_FOUR_P = tsc_pkg::CYC_FOUR,
  parameter int CYC_EIGHT_P = tsc_pkg::CYC_EIGHT
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register byte port
  input wire logic xfer_start_in,
  input wire logic wr_valid_in,
  input wire logic [tsc_pkg::BYTE_W-1:0] wr_byte_in,
  input wire logic rd_req_in,
  output logic [tsc_pkg::BYTE_W-1:0] rd_byte_out,
  output logic rd_valid_out,
  // Bus commands
  input wire logic general_reset_in,
  input wire logic alert_response_in,
  output logic alert_ack_out,
  output logic alert_addr_bit_out,
  // Measurement side
  input wire logic conv_busy_in,
  input wire logic result_valid_in,
  input wire logic [tsc_pkg::IMG_W-1:0] temp_image_in,
  input wire logic [tsc_pkg::IMG_W-1:0] upper_limit_in,
  input wire logic [tsc_pkg::IMG_W-1:0] lower_limit_in,
  output logic conv_start_out,
  output logic conv_abort_out,
  output logic power_down_out,
  output logic range_extend_out,
  // Alert pin
  output logic alert_out
);
  import tsc_pkg::*;

  tsc_ctrl_t ctrl;
  tsc_ctrl_t next_ctrl;
  tsc_byte_t byte_pos;
  tsc_byte_t next_byte_pos;
  tsc_byte_t pos_eff;
  logic conv_idle;
  logic next_conv_idle;
  logic [BYTE_W-1:0] next_rd_byte;
  logic next_rd_valid;
  logic alert_state;
  logic next_alert_state;
  logic next_alert_out;
  logic next_alert_ack;
  logic next_addr_bit;
  logic [RATE_CNT_W-1:0] rate_cnt;
  logic [RATE_CNT_W-1:0] next_rate_cnt;
  logic next_conv_start;
  logic flag_active;
  logic flag_change;
  logic flag_bit;

  function automatic logic [RATE_CNT_W-1:0] rate_last(input logic [1:0] code);
    if (code == RATE_QUARTER) begin
      return RATE_CNT_W'(CYC_QUARTER_P - 1);
    end else if (code == RATE_ONE) begin
      return RATE_CNT_W'(CYC_ONE_P - 1);
    end else if (code == RATE_FOUR) begin
      return RATE_CNT_W'(CYC_FOUR_P - 1);
    end else begin
      return RATE_CNT_W'(CYC_EIGHT_P - 1);
    end
  endfunction

  // ----------------------------------------------------------------
  // Alarm hysteresis
  // ----------------------------------------------------------------
  tsc_fault_filter tsc_fault_filter_inst (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clear_in(general_reset_in),
    .sample_in(result_valid_in),
    .temp_in(tsc_value(temp_image_in, ctrl.em)),
    .upper_in(tsc_value(upper_limit_in, ctrl.em)),
    .lower_in(tsc_value(lower_limit_in, ctrl.em)),
    .fault_q_in(ctrl.fault_q),
    .active_out(flag_active),
    .change_out(flag_change)
  );

  // The flag bit depends only on polarity, never on the mode bit.
  assign flag_bit = ctrl.alert_active_level ? flag_active : !flag_active;

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    pos_eff = xfer_start_in ? TSC_BYTE_HI : byte_pos;
    next_byte_pos = pos_eff;
    next_rd_byte = rd_byte_out;
    next_rd_valid = 1'b0;
    next_conv_idle = !conv_busy_in;
    if (wr_valid_in || rd_req_in) begin
      next_byte_pos = (pos_eff == TSC_BYTE_HI) ? TSC_BYTE_LO : TSC_BYTE_HI;
    end
    if (wr_valid_in && pos_eff == TSC_BYTE_HI) begin
      // Status and resolution bits are not stored.
      next_ctrl.fault_q = wr_byte_in[HI_FQ_HI:HI_FQ_LO];
      next_ctrl.alert_active_level = wr_byte_in[HI_POL];
      next_ctrl.tm = wr_byte_in[HI_TM];
      next_ctrl.sd = wr_byte_in[HI_SD];
    end else if (wr_valid_in) begin
      next_ctrl.rate = wr_byte_in[LO_RATE_HI:LO_RATE_LO];
      next_ctrl.em = wr_byte_in[LO_EM];
    end
    if (rd_req_in) begin
      next_rd_valid = 1'b1;
      if (pos_eff == TSC_BYTE_HI) begin
        next_rd_byte = {conv_idle, RES_CODE, ctrl.fault_q, ctrl.alert_active_level, ctrl.tm,
                        ctrl.sd};
      end else begin
        next_rd_byte = {ctrl.rate, flag_bit, ctrl.em, RSV_VALUE};
      end
    end
    if (general_reset_in) begin
      next_ctrl = CTRL_RESET;
      next_conv_idle = IDLE_RESET;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RESET;
      byte_pos <= TSC_BYTE_HI;
      conv_idle <= IDLE_RESET;
      rd_byte_out <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      byte_pos <= next_byte_pos;
      conv_idle <= next_conv_idle;
      rd_byte_out <= next_rd_byte;
      rd_valid_out <= next_rd_valid;
    end
  end

  // ----------------------------------------------------------------
  // Alert output and alert response
  // ----------------------------------------------------------------
  always_comb begin
    next_alert_state = alert_state;
    next_alert_ack = 1'b0;
    next_addr_bit = flag_active ? ctrl.alert_active_level : !ctrl.alert_active_level;
    if (!ctrl.tm) begin
      next_alert_state = flag_active;
    end else begin
      if (alert_response_in && alert_state) begin
        next_alert_ack = 1'b1;
        next_alert_state = 1'b0;
      end
      // A new flag event in the response cycle is kept.
      if (flag_change) begin
        next_alert_state = 1'b1;
      end
    end
    if (general_reset_in) begin
      next_alert_state = 1'b0;
    end
    next_alert_out = next_alert_state ? next_ctrl.alert_active_level : !next_ctrl.alert_active_level;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      alert_state <= 1'b0;
      alert_out <= 1'b1;
      alert_ack_out <= 1'b0;
      alert_addr_bit_out <= 1'b0;
    end else begin
      alert_state <= next_alert_state;
      alert_out <= next_alert_out;
      alert_ack_out <= next_alert_ack;
      alert_addr_bit_out <= next_addr_bit;
    end
  end

  // ----------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------
  always_comb begin
    next_rate_cnt = rate_cnt + RATE_CNT_W'(1);
    next_conv_start = 1'b0;
    if (ctrl.sd || general_reset_in) begin
      next_rate_cnt = '0;
    end else if (rate_cnt >= rate_last(ctrl.rate)) begin
      next_rate_cnt = '0;
      next_conv_start = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rate_cnt <= '0;
      conv_start_out <= 1'b0;
      conv_abort_out <= 1'b0;
      power_down_out <= CTRL_RESET.sd;
      range_extend_out <= CTRL_RESET.em;
    end else begin
      rate_cnt <= next_rate_cnt;
      conv_start_out <= next_conv_start;
      conv_abort_out <= general_reset_in;
      power_down_out <= next_ctrl.sd;
      range_extend_out <= next_ctrl.em;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_hi_read;
    rd_req_in && !wr_valid_in && pos_eff == TSC_BYTE_HI;
  endsequence

  sequence s_lo_read;
    rd_req_in && !wr_valid_in && !xfer_start_in && byte_pos == TSC_BYTE_LO;
  endsequence

  a_read_resolution: assert property (@(posedge clock_in) disable iff (rst_in)
    s_hi_read |=> rd_valid_out && rd_byte_out[HI_RES_HI:HI_RES_LO] == RES_CODE)
    else $error("resolution code not eleven");

  a_read_pair: assert property (@(posedge clock_in) disable iff (rst_in)
    s_hi_read ##1 s_lo_read |=> rd_byte_out[LO_RSV_HI:LO_RSV_LO] == RSV_VALUE
      && rd_byte_out[LO_EM] == $past(ctrl.em))
    else $error("low byte read wrong");

  a_idle_status: assert property (@(posedge clock_in) disable iff (rst_in)
    s_hi_read and conv_idle |=> rd_byte_out[HI_IDLE])
    else $error("idle status not reported");

  a_write_high: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_valid_in && pos_eff == TSC_BYTE_HI && !general_reset_in |=>
      ctrl.alert_active_level == $past(wr_byte_in[HI_POL]) && byte_pos == TSC_BYTE_LO)
    else $error("high byte write lost");

  a_pin_level: assert property (@(posedge clock_in) disable iff (rst_in)
    alert_out == (alert_state ? ctrl.alert_active_level : !ctrl.alert_active_level))
    else $error("alert pin level wrong");

  a_shutdown_quiet: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl.sd |=> !conv_start_out)
    else $error("conversion started in shutdown");

  a_gcall_restore: assert property (@(posedge clock_in) disable iff (rst_in)
    general_reset_in |=> ctrl == CTRL_RESET && conv_abort_out && !alert_state)
    else $error("general reset incomplete");

  a_irq_release: assert property (@(posedge clock_in) disable iff (rst_in)
    ctrl.tm && alert_state && alert_response_in && !flag_change && !general_reset_in
      |=> alert_ack_out && !alert_state)
    else $error("alert response not honoured");

  a_comp_follow: assert property (@(posedge clock_in) disable iff (rst_in)
    !ctrl.tm && !general_reset_in |=> alert_state == $past(flag_active))
    else $error("comparator alert not following flag");

  a_high_fields: assert property (@(posedge clock_in) disable iff (rst_in)
    s_hi_read |=> rd_byte_out[HI_FQ_HI:HI_FQ_LO] == $past(ctrl.fault_q)
      && rd_byte_out[HI_POL] == $past(ctrl.alert_active_level))
    else $error("high byte fields wrong");

  a_low_write: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_valid_in && pos_eff == TSC_BYTE_LO && !general_reset_in |=>
      ctrl.rate == $past(wr_byte_in[LO_RATE_HI:LO_RATE_LO])
      && ctrl.em == $past(wr_byte_in[LO_EM]))
    else $error("low byte write lost");

  a_flag_polarity: assert property (@(posedge clock_in) disable iff (rst_in)
    s_lo_read |=> rd_byte_out[LO_FLAG] == ($past(ctrl.alert_active_level) ^ !$past(flag_active)))
    else $error("flag bit sense wrong");

  a_abort_source: assert property (@(posedge clock_in) disable iff (rst_in)
    conv_abort_out |-> $past(general_reset_in))
    else $error("abort without general reset");

  a_timer_start: assert property (@(posedge clock_in) disable iff (rst_in)
    !ctrl.sd && !general_reset_in && rate_cnt >= rate_last(ctrl.rate) |=>
      conv_start_out && rate_cnt == '0)
    else $error("conversion start missed");

  a_mode_pins: assert property (@(posedge clock_in) disable iff (rst_in)
    power_down_out == ctrl.sd && range_extend_out == ctrl.em)
    else $error("mode outputs differ from register");

endmodule

// File: tsc_meas_model.sv
// ------------------------------------------------------------
// Conversion engine model
// ------------------------------------------------------------
// Runs one conversion per start pulse and shows the result only
// during the valid pulse; outside it the image is scrambled.
module tsc_meas_model #(
  parameter int BUSY_CYC = 3
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Conversion control
  input wire logic conv_start_in,
  input wire logic conv_abort_in,
  input wire logic [tsc_pkg::IMG_W-1:0] temp_in,
  // Results
  output logic conv_busy_out,
  output logic result_valid_out,
  output logic [tsc_pkg::IMG_W-1:0] temp_image_out
);
  int left;
  always @(negedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      conv_busy_out <= 1'b0;
      result_valid_out <= 1'b0;
      temp_image_out <= ~temp_in;
      left <= 0;
    end else begin
      result_valid_out <= 1'b0;
      temp_image_out <= ~temp_in;
      if (conv_abort_in) begin
        conv_busy_out <= 1'b0;
        left <= 0;
      end else if (conv_start_in && !conv_busy_out) begin
        conv_busy_out <= 1'b1;
        left <= BUSY_CYC;
      end else if (left == 1) begin
        conv_busy_out <= 1'b0;
        left <= 0;
        result_valid_out <= 1'b1;
        temp_image_out <= temp_in;
      end else if (left != 0) begin
        left <= left - 1;
      end
    end
  end
endmodule

// File: temp_sensor_config_register_tb.sv
module temp_sensor_config_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tsc_pkg::*;
  localparam logic [15:0] HOT = 16'h6000;
  localparam logic [15:0] COLD = 16'h1000;
  localparam int PER[4] = '{64, 32, 16, 8};
  localparam int NEED[4] = '{1, 2, 4, 6};
  logic clock_in, rst_in, xfer, wr, rd, greset, aresp, rvalid, ack, addr_bit;
  logic busy, res_v, start, abort, pdown, rext, alert, timed_out;
  logic [7:0] wbyte, rbyte;
  logic [15:0] temp, image, lower;
  logic [7:0] rb [3];
  int mismatches, checks_done, p, c;

  tsc_config_regs #(.CYC_QUARTER_P(64), .CYC_ONE_P(32), .CYC_FOUR_P(16), .CYC_EIGHT_P(8))
    tsc_config_regs_inst (.clock_in(clock_in), .rst_in(rst_in), .xfer_start_in(xfer),
    .wr_valid_in(wr), .wr_byte_in(wbyte), .rd_req_in(rd), .rd_byte_out(rbyte),
    .rd_valid_out(rvalid), .general_reset_in(greset), .alert_response_in(aresp),
    .alert_ack_out(ack), .alert_addr_bit_out(addr_bit), .conv_busy_in(busy),
    .result_valid_in(res_v), .temp_image_in(image), .upper_limit_in(16'h5000),
    .lower_limit_in(lower), .conv_start_out(start), .conv_abort_out(abort),
    .power_down_out(pdown), .range_extend_out(rext), .alert_out(alert));

  tsc_meas_model tsc_meas_model_inst (.clock_in(clock_in), .rst_in(rst_in),
    .conv_start_in(start), .conv_abort_in(abort), .temp_in(temp), .conv_busy_out(busy),
    .result_valid_out(res_v), .temp_image_out(image));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    $display("unexpected wait: expected event, seen timeout");
    timed_out = 1'b1;
    wait (1'b0);
  endtask

  // Waits for a level on one observed signal, counting result pulses and cycles.
  task automatic wait_for(input int sel, input logic val, output int pulses, output int cyc);
    logic s;
    pulses = 0;
    for (int i = 0; i < 400; i++) begin
      @(negedge clock_in);
      pulses += int'(res_v === 1'b1);
      cyc = i + 1;
      case (sel)
        0: s = res_v;
        1: s = busy;
        2: s = alert;
        default: s = start;
      endcase
      if (s === val) return;
    end
    give_up();
  endtask

  task automatic rd_bytes(input int n);
    @(negedge clock_in);
    xfer = 1'b1;
    rd = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clock_in);
      xfer = 1'b0;
      if (i == n - 1) rd = 1'b0;
      check("read strobe", rvalid, 1'b1);
      rb[i] = rbyte;
    end
  endtask

  task automatic wr_pair(input logic [7:0] hi, input logic [7:0] lo);
    @(negedge clock_in);
    xfer = 1'b1;
    wr = 1'b1;
    wbyte = hi;
    @(negedge clock_in);
    xfer = 1'b0;
    wbyte = lo;
    @(negedge clock_in);
    wr = 1'b0;
    wbyte = ~lo;
    @(negedge clock_in);
  endtask

  task automatic hot_then_count(input logic [15:0] t, input logic lvl);
    wait_for(0, 1'b1, p, c);
    temp = t;
    wait_for(2, lvl, p, c);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_defaults();
    wait_for(1, 1'b1, p, c);
    rd_bytes(2);
    check("high byte", rb[0], 8'h60);
    check("low byte", rb[1], 8'hA0);
    check("power down", pdown, 1'b0);
  endtask

  task automatic t_rates();
    for (int k = 0; k < 4; k++) begin
      wr_pair(8'h00, {k[1:0], 6'h00});
      wait_for(3, 1'b1, p, c);
      wait_for(3, 1'b1, p, c);
      check("start period", 16'(c), 16'(PER[k]));
    end
  endtask

  task automatic t_faults();
    for (int k = 0; k < 4; k++) begin
      wr_pair({3'b000, k[1:0], 3'b000}, 8'hC0);
      hot_then_count(HOT, 1'b0);
      check("faults to alarm", 16'(p), 16'(NEED[k]));
      rd_bytes(2);
      check("flag set", rb[1], 8'hC0);
      hot_then_count(COLD, 1'b1);
      check("faults to recover", 16'(p), 16'(NEED[k]));
    end
  endtask

  task automatic t_irq();
    logic got;
    logic bitv;
    wr_pair(8'h06, 8'hC0);
    check("idle alert level", alert, 1'b0);
    hot_then_count(HOT, 1'b1);
    check("interrupt faults", 16'(p), 16'h0001);
    rd_bytes(2);
    check("inverted flag", rb[1], 8'hE0);
    @(negedge clock_in);
    aresp = 1'b1;
    @(negedge clock_in);
    aresp = 1'b0;
    got = ack;
    bitv = addr_bit;
    @(negedge clock_in);
    if (got !== 1'b1) begin
      got = ack;
      bitv = addr_bit;
    end
    check("alert answer", got, 1'b1);
    check("address bit", bitv, 1'b1);
    @(negedge clock_in);
    check("alert released", alert, 1'b0);
    rd_bytes(2);
    check("flag kept", rb[1], 8'hE0);
    hot_then_count(COLD, 1'b1);
    check("interrupt recover", 16'(p), 16'h0001);
  endtask

  task automatic t_readonly();
    wr_pair(8'hFF, 8'hFF);
    repeat (8) @(negedge clock_in);
    check("power down", pdown, 1'b1);
    check("range", rext, 1'b1);
    rd_bytes(3);
    check("high byte", rb[0], 8'hFF);
    check("low byte", rb[1], 8'hD0);
    check("wrapped byte", rb[2], 8'hFF);
    p = 0;
    repeat (70) begin
      @(negedge clock_in);
      p += int'(start === 1'b1);
    end
    check("starts in shutdown", 16'(p), 16'h0000);
  endtask

  task automatic t_greset();
    @(negedge clock_in);
    greset = 1'b1;
    @(negedge clock_in);
    greset = 1'b0;
    check("abort", abort, 1'b1);
    @(negedge clock_in);
    check("abort end", abort, 1'b0);
    check("outputs", {pdown, rext, alert}, 3'b001);
    wait_for(1, 1'b1, p, c);
    rd_bytes(2);
    check("high byte", rb[0], 8'h60);
    check("low byte", rb[1], 8'hA0);
  endtask

  // Raising the lower limit above the present temperature must end the alarm.
  task automatic t_lower();
    hot_then_count(HOT, 1'b0);
    check("alarm before move", 16'(p), 16'h0001);
    wait_for(0, 1'b1, p, c);
    lower = 16'h7000;
    wait_for(2, 1'b1, p, c);
    check("recover on lower", 16'(p), 16'h0001);
    temp = COLD;
    lower = 16'h4B00;
  endtask

  // ------------------------------------------------------------
  // Clock, reset and sequence
  // ------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  initial begin
    wait (timed_out === 1'b1);
    wrap_up();
  end

  initial begin
    {xfer, wr, rd, greset, aresp, timed_out} = '0;
    wbyte = 8'h00;
    temp = COLD;
    lower = 16'h4B00;
    mismatches = 0;
    checks_done = 0;
    rst_in = 1'b1;
    repeat (4) @(negedge clock_in);
    check("reset read byte", rbyte, 8'h00);
    check("reset alert", alert, 1'b1);
    rst_in = 1'b0;
    t_defaults();
    t_rates();
    t_faults();
    t_irq();
    t_readonly();
    t_greset();
    t_lower();
    wrap_up();
  end
endmodule
